// file: rtl/ddrcd_top.sv
// command decoder front end of an eight-bank DDR3 device
// How it works
// - RAS low, CAS high: activate if WE high, precharge if low; AP picks one/all.
// - Refresh is CS/RAS/CAS low, WE high, CKE high twice; CS high deselects.
// - Write: CS low, RAS high, CAS/WE low, CKE high, bank active.
// - On-the-fly write: chop bit low gives four beats, high gives eight.
// - Read: CS low, RAS high, CAS low, WE high, CKE high, bank active.
// - On-the-fly read: chop bit high gives eight beats, low gives four.
// - Auto precharge bit with read/write closes the bank after the burst.
// - Mode register set: all strobes low, CKE high, idle only; bank picks register.
// - Refresh with CKE falling enters self refresh; CKE rising with NOP exits.
// - CKE falling with NOP or deselect enters power-down.
// - CKE rising with NOP or deselect leaves power-down from any bank state.
// - Write beats with data mask high are discarded, low ones written.
// - Lower and upper byte masks act independently on every beat.
// - Lower mask gates data bits 0-7, upper mask gates bits 8-15.
// - Read, write and activate checks use the bank picked by the bank address; other checks need all banks idle.
// - Eight banks open and close independently.
// - One core access of eight words, two words per clock over four clocks.
// - Bursts of eight or chopped four beats from the start column.
// - Activate latches the bank from bank address and row from A0-A12.
// - Start column from address; chop bit used only when on-the-fly enabled.
`timescale 1ns/1ps
module ddrcd_top
   import ddrcd_pkg::*;
#(
   parameter int unsigned BANKS = NUM_BANKS,
   parameter int unsigned DQW   = DQ_W
) (
   // clock and reset
   input  wire logic                  i_core_clk,
   input  wire logic                  i_arst_n,
   // command pins, sampled each rising edge
   input  wire logic                  i_cke,
   input  wire logic                  i_chip_select_n,
   input  wire logic                  i_row_strobe_n,
   input  wire logic                  i_column_strobe_n,
   input  wire logic                  i_write_strobe_n,
   input  wire logic [BANK_W-1:0]     i_bank_address,
   input  wire logic [ADDR_W-1:0]     i_address,
   // configuration from the mode register
   input  wire logic                  i_otf_enable,
   input  wire logic                  i_fixed_chop,
   // write data, two beats per clock (rise then fall)
   input  wire logic [DQW-1:0]        i_wdata_rise,
   input  wire logic [DQW-1:0]        i_wdata_fall,
   input  wire logic [1:0]            i_lower_byte_mask,
   input  wire logic [1:0]            i_upper_byte_mask,
   // decoded command
   output ddrcd_cmd_t                 o_cmd,
   output logic                       o_cmd_illegal,
   output logic [BANK_W-1:0]          o_cmd_bank,
   // mode register write
   output logic                       o_mrs_valid,
   output logic [BANK_W-1:0]          o_mrs_select,
   output logic [ADDR_W-1:0]          o_mrs_opcode,
   // burst in progress
   output logic                       o_burst_active,
   output logic                       o_burst_is_write,
   output logic                       o_burst_chop,
   output logic [ROW_W-1:0]           o_burst_row,
   output logic [COL_W-1:0]           o_burst_col,
   output logic [2:0]                 o_burst_beat,
   // masked write beats to the core, pair per clock
   output logic                       o_wbeat_valid,
   output logic [2*DQW-1:0]           o_wbeat_data,
   output logic [3:0]                 o_wbeat_lane_en,
   // device state
   output ddrcd_state_t               o_power_state,
   output logic [BANKS-1:0]           o_bank_open
);
   if (BANKS != NUM_BANKS || DQW != 2 * LANE_W) begin : g_bad_params
      $error("ddrcd_top: eight banks and two byte lanes are required");
   end

   logic          cke_prev_q;
   ddrcd_state_t  state_q;
   logic [BANKS-1:0]      bank_open;
   logic [ROW_W-1:0]      bank_row [BANKS];
   logic [BANKS-1:0]      act_vec;
   logic [BANKS-1:0]      pre_vec;
   logic [BANKS-1:0]      ap_vec;

   // the previous CKE level is held to compare against the current one
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cke_prev_q <= 1'b0;
      end else begin
         cke_prev_q <= i_cke;
      end
   end

   // raw pin encodings
   logic enc_nop, enc_desel, enc_act, enc_pre, enc_rd, enc_wr, enc_mrs, enc_ref, enc_zq;
   logic cke_hh, cke_hl, cke_lh, all_idle, sel_open, normal, ap, chop_sel;

   always_comb begin
      enc_desel = i_chip_select_n;
      enc_nop   = !i_chip_select_n && i_row_strobe_n && i_column_strobe_n
                  && i_write_strobe_n;
      enc_act   = !i_chip_select_n && !i_row_strobe_n && i_column_strobe_n
                  && i_write_strobe_n;
      enc_pre   = !i_chip_select_n && !i_row_strobe_n && i_column_strobe_n
                  && !i_write_strobe_n;
      enc_wr    = !i_chip_select_n && i_row_strobe_n && !i_column_strobe_n
                  && !i_write_strobe_n;
      enc_rd    = !i_chip_select_n && i_row_strobe_n && !i_column_strobe_n
                  && i_write_strobe_n;
      enc_mrs   = !i_chip_select_n && !i_row_strobe_n && !i_column_strobe_n
                  && !i_write_strobe_n;
      enc_ref   = !i_chip_select_n && !i_row_strobe_n && !i_column_strobe_n
                  && i_write_strobe_n;
      enc_zq    = !i_chip_select_n && i_row_strobe_n && i_column_strobe_n
                  && !i_write_strobe_n;
      cke_hh    = cke_prev_q && i_cke;
      cke_hl    = cke_prev_q && !i_cke;
      cke_lh    = !cke_prev_q && i_cke;
      all_idle  = (bank_open == '0);
      sel_open  = bank_open[i_bank_address];
      normal    = (state_q == DDRCD_ST_NORMAL);
      ap        = i_address[AP_BIT];
      // chop bit honoured only in on-the-fly mode, else fixed setting
      chop_sel  = i_otf_enable ? !i_address[BC_BIT] : i_fixed_chop;
   end

   // a burst owns the data path; a new column command during one is refused
   logic burst_q, rd_ok, wr_ok, act_ok;
   always_comb begin
      rd_ok  = normal && cke_hh && enc_rd && sel_open && !burst_q;
      wr_ok  = normal && cke_hh && enc_wr && sel_open && !burst_q;
      act_ok = normal && cke_hh && enc_act && !sel_open;
   end

   // command classification, reported one clock later
   ddrcd_cmd_t cmd_d;
   logic       illegal_d;
   always_comb begin
      cmd_d     = DDRCD_CMD_NONE;
      illegal_d = 1'b0;
      case (state_q)
         DDRCD_ST_SELF: begin
            if (cke_lh && (enc_nop || enc_desel)) cmd_d = DDRCD_CMD_SRX;
         end
         DDRCD_ST_PDOWN: begin
            if (cke_lh && (enc_nop || enc_desel)) cmd_d = DDRCD_CMD_PDX;
         end
         DDRCD_ST_NORMAL: begin
            if (cke_hl && enc_ref) begin
               cmd_d     = all_idle ? DDRCD_CMD_SRE : DDRCD_CMD_NONE;
               illegal_d = !all_idle;
            end else if (cke_hl && (enc_nop || enc_desel)) begin
               cmd_d = DDRCD_CMD_PDE;
            end else if (cke_hh) begin
               if (enc_desel) begin
                  cmd_d = DDRCD_CMD_DESEL;
               end else if (enc_nop) begin
                  cmd_d = DDRCD_CMD_NOP;
               end else if (enc_act) begin
                  cmd_d     = act_ok ? DDRCD_CMD_ACT : DDRCD_CMD_NONE;
                  illegal_d = !act_ok;
               end else if (enc_pre) begin
                  cmd_d = ap ? DDRCD_CMD_PREA : DDRCD_CMD_PRE;
               end else if (enc_rd) begin
                  cmd_d     = rd_ok ? DDRCD_CMD_RD : DDRCD_CMD_NONE;
                  illegal_d = !rd_ok;
               end else if (enc_wr) begin
                  cmd_d     = wr_ok ? DDRCD_CMD_WR : DDRCD_CMD_NONE;
                  illegal_d = !wr_ok;
               end else if (enc_mrs) begin
                  cmd_d     = all_idle ? DDRCD_CMD_MRS : DDRCD_CMD_NONE;
                  illegal_d = !all_idle;
               end else if (enc_ref) begin
                  cmd_d     = all_idle ? DDRCD_CMD_REF : DDRCD_CMD_NONE;
                  illegal_d = !all_idle;
               end else if (enc_zq) begin
                  cmd_d     = !all_idle ? DDRCD_CMD_NONE
                              : (ap ? DDRCD_CMD_ZQL : DDRCD_CMD_ZQS);
                  illegal_d = !all_idle;
               end
            end
         end
         default: begin
            cmd_d = DDRCD_CMD_NONE;
         end
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_cmd         <= DDRCD_CMD_NONE;
         o_cmd_illegal <= 1'b0;
         o_cmd_bank    <= BANK_ZERO;
      end else begin
         o_cmd         <= cmd_d;
         o_cmd_illegal <= illegal_d;
         o_cmd_bank    <= i_bank_address;
      end
   end

   // power state machine
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_q <= DDRCD_ST_NORMAL;
      end else begin
         case (cmd_d)
            DDRCD_CMD_SRE: state_q <= DDRCD_ST_SELF;
            DDRCD_CMD_PDE: state_q <= DDRCD_ST_PDOWN;
            DDRCD_CMD_SRX: state_q <= DDRCD_ST_NORMAL;
            DDRCD_CMD_PDX: state_q <= DDRCD_ST_NORMAL;
            default:       state_q <= state_q;
         endcase
      end
   end

   // mode register write: bank address selects register, address is opcode
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_mrs_valid  <= 1'b0;
         o_mrs_select <= BANK_ZERO;
         o_mrs_opcode <= '0;
      end else begin
         o_mrs_valid <= (cmd_d == DDRCD_CMD_MRS);
         if (cmd_d == DDRCD_CMD_MRS) begin
            o_mrs_select <= i_bank_address;
            o_mrs_opcode <= i_address;
         end
      end
   end

   // burst framing: four clocks of two beats for eight, two clocks for four
   logic [3:0]        beats_left_q;
   logic              burst_ap_q;
   logic [BANK_W-1:0] burst_bank_q;
   logic              burst_end;
   assign burst_end = burst_q && (beats_left_q <= BEAT_STEP);

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         burst_q          <= 1'b0;
         beats_left_q     <= BEAT_ZERO;
         burst_ap_q       <= 1'b0;
         burst_bank_q     <= BANK_ZERO;
         o_burst_is_write <= 1'b0;
         o_burst_chop     <= 1'b0;
         o_burst_col      <= '0;
         o_burst_beat     <= '0;
      end else if (rd_ok || wr_ok) begin
         burst_q          <= 1'b1;
         beats_left_q     <= chop_sel ? BEAT_CNT_CHOP : BEAT_CNT_FULL;
         burst_ap_q       <= ap;
         burst_bank_q     <= i_bank_address;
         o_burst_is_write <= wr_ok;
         o_burst_chop     <= chop_sel;
         o_burst_col      <= i_address[COL_W-1:0];
         o_burst_beat     <= '0;
      end else if (burst_q) begin
         burst_q      <= !burst_end;
         beats_left_q <= beats_left_q - BEAT_STEP;
         o_burst_beat <= o_burst_beat + 3'(BEAT_STEP);
      end
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_burst_active <= 1'b0;
         o_burst_row    <= '0;
      end else begin
         o_burst_active <= (rd_ok || wr_ok) || (burst_q && !burst_end);
         if (rd_ok || wr_ok) begin
            o_burst_row <= bank_row[i_bank_address];
         end
      end
   end

   // masked write beats: one lane enable per byte per beat
   logic [3:0] lane_en;
   always_comb begin
      lane_en[0] = !i_lower_byte_mask[0];   // rise, bits 0-7
      lane_en[1] = !i_upper_byte_mask[0];   // rise, bits 8-15
      lane_en[2] = !i_lower_byte_mask[1];   // fall, bits 0-7
      lane_en[3] = !i_upper_byte_mask[1];   // fall, bits 8-15
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_wbeat_valid   <= 1'b0;
         o_wbeat_data    <= '0;
         o_wbeat_lane_en <= 4'h0;
      end else begin
         // data beats follow the column command by one clock, so they are
         // taken while the registered burst frame is open
         o_wbeat_valid   <= burst_q && o_burst_is_write;
         o_wbeat_data    <= {i_wdata_fall, i_wdata_rise};
         o_wbeat_lane_en <= (burst_q && o_burst_is_write) ? lane_en : 4'h0;
      end
   end

   // per-bank activate, precharge and auto precharge strobes
   always_comb begin
      for (int b = 0; b < BANKS; b++) begin
         act_vec[b] = act_ok && (i_bank_address == b[BANK_W-1:0]);
         pre_vec[b] = (cmd_d == DDRCD_CMD_PREA) ||
                      ((cmd_d == DDRCD_CMD_PRE) && (i_bank_address == b[BANK_W-1:0]));
         ap_vec[b]  = burst_end && burst_ap_q
                      && (burst_bank_q == b[BANK_W-1:0]);
      end
   end

   genvar g;
   generate
      for (g = 0; g < BANKS; g++) begin : g_bank
         ddrcd_bank #(.ROWS_W(ROW_W)) u_bank (
            .i_core_clk  (i_core_clk),
            .i_arst_n    (i_arst_n),
            .i_activate  (act_vec[g]),
            .i_precharge (pre_vec[g]),
            .i_auto_pre  (ap_vec[g]),
            .i_row       (i_address[ROW_W-1:0]),
            .o_open      (bank_open[g]),
            .o_row       (bank_row[g])
         );
      end
   endgenerate

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_power_state <= DDRCD_ST_NORMAL;
         o_bank_open   <= '0;
      end else begin
         o_power_state <= state_q;
         o_bank_open   <= bank_open;
      end
   end
endmodule

// file: rtl/ddrcd_pkg.sv
// constants and types shared by the command decoder files
package ddrcd_pkg;
   localparam int unsigned NUM_BANKS     = 8;
   localparam int unsigned BANK_W        = 3;
   localparam int unsigned ROW_W         = 13;
   localparam int unsigned COL_W         = 10;
   localparam int unsigned ADDR_W        = 13;
   localparam int unsigned DQ_W          = 16;
   localparam int unsigned LANE_W        = 8;
   localparam int unsigned AP_BIT        = 10;
   localparam int unsigned BC_BIT        = 12;
   localparam int unsigned BEATS_FULL    = 8;
   localparam int unsigned BEATS_CHOP    = 4;
   localparam logic [3:0]  BEAT_CNT_FULL = 4'h8;
   localparam logic [3:0]  BEAT_CNT_CHOP = 4'h4;
   localparam logic [3:0]  BEAT_ZERO     = 4'h0;
   localparam logic [3:0]  BEAT_ONE      = 4'h1;
   localparam logic [3:0]  BEAT_STEP     = 4'h2;
   localparam logic [2:0]  BANK_ZERO     = 3'h0;

   // command code reported on o_cmd
   typedef enum logic [3:0] {
      DDRCD_CMD_NONE  = 4'h0,
      DDRCD_CMD_DESEL = 4'h1,
      DDRCD_CMD_NOP   = 4'h2,
      DDRCD_CMD_ACT   = 4'h3,
      DDRCD_CMD_PRE   = 4'h4,
      DDRCD_CMD_PREA  = 4'h5,
      DDRCD_CMD_RD    = 4'h6,
      DDRCD_CMD_WR    = 4'h7,
      DDRCD_CMD_MRS   = 4'h8,
      DDRCD_CMD_REF   = 4'h9,
      DDRCD_CMD_SRE   = 4'hA,
      DDRCD_CMD_SRX   = 4'hB,
      DDRCD_CMD_PDE   = 4'hC,
      DDRCD_CMD_PDX   = 4'hD,
      DDRCD_CMD_ZQL   = 4'hE,
      DDRCD_CMD_ZQS   = 4'hF
   } ddrcd_cmd_t;

   typedef enum logic [1:0] {
      DDRCD_ST_NORMAL = 2'b00,
      DDRCD_ST_SELF   = 2'b01,
      DDRCD_ST_PDOWN  = 2'b10
   } ddrcd_state_t;
endpackage

// file: rtl/ddrcd_bank.sv
`timescale 1ns/1ps
// one bank: open flag and open row; precharge or auto precharge closes it
module ddrcd_bank
   import ddrcd_pkg::*;
#(
   parameter int unsigned ROWS_W = ROW_W
) (
   // clock and reset
   input  wire logic              i_core_clk,
   input  wire logic              i_arst_n,
   // events for this bank
   input  wire logic              i_activate,
   input  wire logic              i_precharge,
   input  wire logic              i_auto_pre,
   input  wire logic [ROWS_W-1:0] i_row,
   // state
   output logic                   o_open,
   output logic [ROWS_W-1:0]      o_row
);
   if (ROWS_W < 1) begin : g_bad_rows
      $error("ddrcd_bank: row width must be positive");
   end

   // precharge wins over activate only if both named the same bank, which
   // the decoder never produces; auto precharge closes after the burst
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_open <= 1'b0;
      end else if (i_precharge || i_auto_pre) begin
         o_open <= 1'b0;
      end else if (i_activate) begin
         o_open <= 1'b1;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_row <= '0;
      end else if (i_activate) begin
         o_row <= i_row;
      end
   end
endmodule

// file: sim/ddrcd_asserts.sv
// concurrent checks on the command decoder ports
`timescale 1ns/1ps
module ddrcd_asserts
   import ddrcd_pkg::*;
#(
   parameter int unsigned BANKS = NUM_BANKS
) (
   // clock, reset and pins
   input wire logic              i_core_clk,
   input wire logic              i_arst_n,
   input wire logic              i_cke,
   input wire logic              i_chip_select_n,
   input wire logic [BANK_W-1:0] i_bank_address,
   input wire logic [ADDR_W-1:0] i_address,
   input wire logic              i_otf_enable,
   input wire logic              i_fixed_chop,
   input wire logic [1:0]        i_lower_byte_mask,
   input wire logic [1:0]        i_upper_byte_mask,
   // decoder outputs
   input wire ddrcd_cmd_t        o_cmd,
   input wire logic [BANK_W-1:0] o_cmd_bank,
   input wire logic              o_mrs_valid,
   input wire logic [BANK_W-1:0] o_mrs_select,
   input wire logic [ADDR_W-1:0] o_mrs_opcode,
   input wire logic              o_burst_active,
   input wire logic              o_burst_chop,
   input wire logic [2:0]        o_burst_beat,
   input wire logic              o_wbeat_valid,
   input wire logic [3:0]        o_wbeat_lane_en,
   input wire logic [BANKS-1:0]  o_bank_open
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_arst_n);
   logic cke_q;
   wire  col_cmd = (o_cmd == DDRCD_CMD_RD) | (o_cmd == DDRCD_CMD_WR);
   // mirrors the decoder's previous cke, which also reads low after reset
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cke_q <= 1'b0;
      end else begin
         cke_q <= i_cke;
      end
   end
   AST_DESELECT: assert property (
      i_chip_select_n && i_cke && cke_q |=> o_cmd == DDRCD_CMD_DESEL)
      else $error("deselect not decoded");
   AST_ACT_OPENS: assert property (
      o_cmd == DDRCD_CMD_ACT |=> o_bank_open[$past(o_cmd_bank)])
      else $error("activated bank not open");
   AST_FULL_BURST: assert property (
      col_cmd && !o_burst_chop |-> o_burst_active && o_burst_beat == 3'h0
      ##1 o_burst_active && o_burst_beat == 3'h2 ##1 o_burst_active && o_burst_beat == 3'h4
      ##1 o_burst_active && o_burst_beat == 3'h6)
      else $error("eight beat frame wrong");
   AST_CHOP_BURST: assert property (
      col_cmd && o_burst_chop |-> o_burst_active && o_burst_beat == 3'h0
      ##1 o_burst_active && o_burst_beat == 3'h2)
      else $error("four beat frame wrong");
   AST_CHOP_SELECT: assert property (
      col_cmd |-> o_burst_chop == ($past(i_otf_enable) ? !$past(i_address[12])
                                                        : $past(i_fixed_chop)))
      else $error("burst length selection wrong");
   AST_LANES: assert property (
      o_wbeat_valid |-> o_wbeat_lane_en == ~{$past(i_upper_byte_mask[1]),
         $past(i_lower_byte_mask[1]), $past(i_upper_byte_mask[0]), $past(i_lower_byte_mask[0])})
      else $error("lane enables do not follow masks");
   AST_WR_BEATS: assert property (
      o_cmd == DDRCD_CMD_WR |=> o_wbeat_valid [*2])
      else $error("write beats missing");
   AST_MRS: assert property (
      o_mrs_valid |-> o_cmd == DDRCD_CMD_MRS && o_mrs_select == $past(i_bank_address)
                      && o_mrs_opcode == $past(i_address))
      else $error("mode register write wrong");
endmodule

// file: sim/ddrcd_ctrl_model.sv
// controller-side command driver for the decoder bench
`timescale 1ns/1ps
module ddrcd_ctrl_model
   import ddrcd_pkg::*;
(
   // clock
   input  wire logic          i_core_clk,
   // command pins toward the device, {cs,ras,cas,we} active low
   output logic              o_cke,
   output logic [3:0]        o_pins,
   output logic [BANK_W-1:0] o_ba,
   output logic [ADDR_W-1:0] o_addr
);
   initial begin
      o_cke  = 1'b0;
      o_pins = 4'hF;
      o_ba   = 3'h0;
      o_addr = 13'h0000;
   end
   // one command, then nop; cke keeps the command's level, idle lines toggle
   task automatic issue(input logic [3:0] p, input logic ck, input logic [2:0] b,
                        input logic [12:0] a);
      @(posedge i_core_clk);
      o_pins <= p;
      o_cke  <= ck;
      o_ba   <= b;
      o_addr <= a;
      @(posedge i_core_clk);
      o_pins <= 4'h7;
      o_ba   <= ~b;
      o_addr <= ~a;
   endtask
endmodule

// file: sim/ddrcd_top_tb.sv
// self-checking bench for the command decoder
`timescale 1ns/1ps
module ddrcd_top_tb;
   import ddrcd_pkg::*;
   localparam int unsigned BANKS = NUM_BANKS;
   localparam logic [3:0] P_ACT = 4'h3, P_PRE = 4'h2, P_WR = 4'h4, P_RD = 4'h5;
   localparam logic [3:0] P_MRS = 4'h0, P_REF = 4'h1, P_ZQ = 4'h6, P_NOP = 4'h7, P_DES = 4'hF;
   logic              i_core_clk, i_arst_n, i_cke, i_otf_enable, i_fixed_chop;
   wire logic         i_chip_select_n, i_row_strobe_n, i_column_strobe_n, i_write_strobe_n;
   logic [3:0]        pins, o_wbeat_lane_en;
   logic [BANK_W-1:0] i_bank_address, o_cmd_bank, o_mrs_select;
   logic [ADDR_W-1:0] i_address, o_mrs_opcode;
   logic [DQ_W-1:0]   i_wdata_rise, i_wdata_fall;
   logic [1:0]        i_lower_byte_mask, i_upper_byte_mask;
   logic              o_cmd_illegal, o_mrs_valid, o_burst_active, o_burst_is_write;
   logic              o_burst_chop, o_wbeat_valid;
   logic [ROW_W-1:0]  o_burst_row;
   logic [COL_W-1:0]  o_burst_col;
   logic [2:0]        o_burst_beat;
   logic [31:0]       o_wbeat_data, m;
   logic [7:0]        o_bank_open;
   logic [35:0]       e;
   ddrcd_cmd_t        o_cmd;
   ddrcd_state_t      o_power_state;
   logic [ROW_W-1:0]  erow [NUM_BANKS];
   logic [35:0]       exp_q[$];
   int                fails, n_tests;
   assign {i_chip_select_n, i_row_strobe_n, i_column_strobe_n, i_write_strobe_n} = pins;
   ddrcd_ctrl_model u_ctl (.i_core_clk, .o_cke(i_cke), .o_pins(pins), .o_ba(i_bank_address),
      .o_addr(i_address));
   ddrcd_top DUT (.i_core_clk, .i_arst_n, .i_cke, .i_chip_select_n, .i_row_strobe_n,
      .i_column_strobe_n, .i_write_strobe_n, .i_bank_address, .i_address, .i_otf_enable,
      .i_fixed_chop, .i_wdata_rise, .i_wdata_fall, .i_lower_byte_mask, .i_upper_byte_mask,
      .o_cmd, .o_cmd_illegal, .o_cmd_bank, .o_mrs_valid, .o_mrs_select, .o_mrs_opcode,
      .o_burst_active, .o_burst_is_write, .o_burst_chop, .o_burst_row, .o_burst_col,
      .o_burst_beat, .o_wbeat_valid, .o_wbeat_data, .o_wbeat_lane_en, .o_power_state,
      .o_bank_open);
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      n_tests++;
      if (s !== x) begin
         fails++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, s, x);
      end
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic cmd(input logic [3:0] p, input logic ck, input logic [2:0] b,
                      input logic [12:0] a, input ddrcd_cmd_t ec, input logic ei);
      u_ctl.issue(p, ck, b, a);
      #1;
      chk(32'(o_cmd), 32'(ec));
      chk(32'(o_cmd_illegal), 32'(ei));
   endtask
   task automatic act(input logic [2:0] b, input logic [12:0] r);
      cmd(P_ACT, 1'b1, b, r, DDRCD_CMD_ACT, 1'b0);
      chk(32'(o_cmd_bank), 32'(b));
      erow[b] = r;
   endtask
   // registered state lags the command by a cycle or two
   task automatic lag_chk(input logic [31:0] s_sel, input logic [31:0] x);
      repeat (2) @(posedge i_core_clk);
      #1;
      chk(s_sel ? 32'(o_power_state) : 32'(o_bank_open), x);
   endtask
   task automatic burst(input logic wr, input logic [2:0] b, input logic [9:0] c,
                        input logic ap, input logic bc, input logic ch);
      int n;
      n = ch ? 2 : 4;
      fork
         begin
            cmd(wr ? P_WR : P_RD, 1'b1, b, {bc, 1'b0, ap, c},
                wr ? DDRCD_CMD_WR : DDRCD_CMD_RD, 1'b0);
            chk(32'({o_burst_active, o_burst_chop, o_burst_is_write}),
                32'({1'b1, ch, wr}));
            chk(32'({o_burst_row, o_burst_col}), 32'({erow[b], c}));
         end
         begin
            repeat (2) @(posedge i_core_clk);
            for (int j = 0; j < n; j++) begin
               logic [1:0]  l;
               logic [1:0]  u;
               logic [15:0] r;
               l = 2'(j);
               u = 2'(3 - j);
               r = 16'h1234 + 16'(j * 257);
               i_wdata_rise <= r;
               i_wdata_fall <= ~r;
               i_lower_byte_mask <= l;
               i_upper_byte_mask <= u;
               if (wr)
                  exp_q.push_back({~u[1], ~l[1], ~u[0], ~l[0], ~r, r});
               @(posedge i_core_clk);
            end
            i_lower_byte_mask <= 2'h3;
            i_upper_byte_mask <= 2'h3;
         end
      join
      #1;
      chk(32'(o_burst_active), 32'h0);
   endtask
   // masked lanes carry no obligation on data, so only enabled bytes are compared
   always @(posedge i_core_clk) begin
      if (o_wbeat_valid === 1'b1) begin
         chk(32'(exp_q.size() > 0), 32'h1);
         e = exp_q.pop_front();
         m = {{8{e[35]}}, {8{e[34]}}, {8{e[33]}}, {8{e[32]}}};
         chk(32'(o_wbeat_lane_en), 32'(e[35:32]));
         chk(o_wbeat_data & m, e[31:0] & m);
      end
   end
   initial begin
      i_core_clk = 1'b0;
      forever #5 i_core_clk = ~i_core_clk;
   end
   initial begin
      #100000;
      fails++;
      final_report();
   end
   initial begin
      i_arst_n = 1'b0;
      i_otf_enable = 1'b1;
      i_fixed_chop = 1'b0;
      i_wdata_rise = 16'h0000;
      i_wdata_fall = 16'h0000;
      i_lower_byte_mask = 2'h3;
      i_upper_byte_mask = 2'h3;
      repeat (3) @(posedge i_core_clk);
      i_arst_n <= 1'b1;
      #1;
      chk(32'({o_cmd, o_power_state, o_bank_open}), 32'h0);
      u_ctl.issue(P_NOP, 1'b1, 3'h0, 13'h0000);
      cmd(P_DES, 1'b1, 3'h5, 13'h1FFF, DDRCD_CMD_DESEL, 1'b0);
      cmd(P_NOP, 1'b1, 3'h1, 13'h0555, DDRCD_CMD_NOP, 1'b0);
      act(3'h2, 13'h1ABC);
      act(3'h5, 13'h0F0F);
      lag_chk(0, 32'h24);
      cmd(P_ACT, 1'b1, 3'h2, 13'h0000, DDRCD_CMD_NONE, 1'b1);
      cmd(P_RD, 1'b1, 3'h0, 13'h0000, DDRCD_CMD_NONE, 1'b1);
      cmd(P_MRS, 1'b1, 3'h1, 13'h0000, DDRCD_CMD_NONE, 1'b1);
      cmd(P_ZQ, 1'b1, 3'h0, 13'h0400, DDRCD_CMD_NONE, 1'b1);
      for (int i = 0; i < 8; i++) begin
         @(posedge i_core_clk);
         i_otf_enable <= ~i[1];
         i_fixed_chop <= i[2];
         burst(i[0], 3'h2, 10'(i * 8 + 3), 1'b0, i[2], i[1] ? i[2] : ~i[2]);
      end
      burst(1'b0, 3'h5, 10'h3F0, 1'b1, 1'b1, 1'b1);
      lag_chk(0, 32'h04);
      cmd(P_RD, 1'b1, 3'h5, 13'h0000, DDRCD_CMD_NONE, 1'b1);
      cmd(P_PRE, 1'b1, 3'h2, 13'h0000, DDRCD_CMD_PRE, 1'b0);
      lag_chk(0, 32'h00);
      act(3'h1, 13'h0042);
      cmd(P_PRE, 1'b1, 3'h0, 13'h0400, DDRCD_CMD_PREA, 1'b0);
      lag_chk(0, 32'h00);
      cmd(P_MRS, 1'b1, 3'h3, 13'h0ABC, DDRCD_CMD_MRS, 1'b0);
      chk(32'({o_mrs_valid, o_mrs_select, o_mrs_opcode}), 32'({1'b1, 3'h3, 13'h0ABC}));
      cmd(P_REF, 1'b1, 3'h0, 13'h0000, DDRCD_CMD_REF, 1'b0);
      cmd(P_ZQ, 1'b1, 3'h0, 13'h0400, DDRCD_CMD_ZQL, 1'b0);
      cmd(P_ZQ, 1'b1, 3'h0, 13'h0000, DDRCD_CMD_ZQS, 1'b0);
      cmd(P_REF, 1'b0, 3'h0, 13'h0000, DDRCD_CMD_SRE, 1'b0);
      lag_chk(1, 32'(DDRCD_ST_SELF));
      cmd(P_NOP, 1'b1, 3'h0, 13'h0000, DDRCD_CMD_SRX, 1'b0);
      lag_chk(1, 32'(DDRCD_ST_NORMAL));
      act(3'h6, 13'h0123);
      cmd(P_DES, 1'b0, 3'h0, 13'h0000, DDRCD_CMD_PDE, 1'b0);
      lag_chk(1, 32'(DDRCD_ST_PDOWN));
      cmd(P_NOP, 1'b1, 3'h0, 13'h0000, DDRCD_CMD_PDX, 1'b0);
      lag_chk(0, 32'h40);
      chk(32'(exp_q.size()), 32'h0);
      final_report();
   end
endmodule
bind ddrcd_top ddrcd_asserts #(.BANKS(BANKS)) u_ast (.i_core_clk, .i_arst_n, .i_cke,
   .i_chip_select_n, .i_bank_address, .i_address, .i_otf_enable, .i_fixed_chop,
   .i_lower_byte_mask, .i_upper_byte_mask, .o_cmd, .o_cmd_bank, .o_mrs_valid, .o_mrs_select,
   .o_mrs_opcode, .o_burst_active, .o_burst_chop, .o_burst_beat, .o_wbeat_valid,
   .o_wbeat_lane_en, .o_bank_open);
